// >>> verilog/hw_load_pkg.sv
package hw_load_pkg;
   localparam int unsigned word_w = 32;
   localparam int unsigned half_w = 16;
   localparam int unsigned reg_count = 32;
   localparam int unsigned sel_w = 5;
   localparam int unsigned byte_w = 8;
   // Instruction field positions; the word's bit 0 is its least significant bit
   localparam int unsigned op_msb = 31;
   localparam int unsigned op_lsb = 26;
   localparam int unsigned target_msb = 25;
   localparam int unsigned target_lsb = 21;
   localparam int unsigned base_msb = 20;
   localparam int unsigned base_lsb = 16;
   localparam int unsigned index_msb = 15;
   localparam int unsigned index_lsb = 11;
   localparam int unsigned xo_msb = 10;
   localparam int unsigned xo_lsb = 1;
   // Opcodes and extended opcodes of the decoded loads
   localparam logic [5:0] op_indexed = 6'h1F;
   localparam logic [5:0] op_half_unsigned = 6'h28;
   localparam logic [9:0] xo_signed_update = 10'h177;
   localparam logic [9:0] xo_signed_indexed = 10'h157;
   localparam logic [9:0] xo_swapped_indexed = 10'h316;
   localparam logic [sel_w-1:0] reg_zero = 5'h00;
   localparam logic [word_w-1:0] word_zero = 32'h00000000;
   localparam logic [half_w-1:0] half_zero = 16'h0000;

   typedef enum {
      load_none,
      load_signed_update,
      load_signed,
      load_swapped,
      load_unsigned
   } load_kind_t;

   typedef enum {
      st_idle,
      st_wait
   } phase_t;

   // Memory request toward the data side
   typedef struct packed {
      logic valid;
      logic [word_w-1:0] addr;
   } mem_req_t;

   // Register write-back port, up to two writes per load
   typedef struct packed {
      logic target_we;
      logic [sel_w-1:0] target_sel;
      logic [word_w-1:0] target_data;
      logic base_we;
      logic [sel_w-1:0] base_sel;
      logic [word_w-1:0] base_data;
   } wb_t;
endpackage

// >>> verilog/halfword_load_execute.sv
`timescale 1ns/100ps
// Behaviour
// - Opcode 31 with extended 375 decodes the signed update indexed load.
// - Opcode 31 with extended 343 decodes the signed indexed load.
// - Opcode 31 with extended 790 decodes the byte-swapped indexed load.
// - Opcode 40 decodes unsigned load; target 6-10, base 11-15, offset 16-31.
// - Indexed fields: target 6-10, base 11-15, index 16-20; bit 31 unused.
// - Indexed address is base plus index, or index alone when base is zero.
// - Unsigned address is base plus sign-extended offset, or offset alone.
// - Signed loads put halfword low and copy its sign into upper bits.
// - Unsigned load puts halfword low and clears upper bits.
// - Swapped load exchanges halfword bytes and clears upper bits.
// - Update writes address to base when base nonzero, not target, no fault.
// - Exception register untouched; unsigned and swapped keep condition field 0.
module halfword_load_execute
   import hw_load_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic instr_valid,
   input wire logic [word_w-1:0] instr_word,
   output logic instr_ready,
   output logic instr_illegal,
   output mem_req_t mem_req,
   input wire logic mem_ack,
   input wire logic [half_w-1:0] mem_rdata,
   input wire logic mem_align_fault,
   input wire logic mem_storage_fault,
   output wb_t wb,
   output logic load_fault,
   output logic cr0_update,
   output logic xer_update,
   input wire logic [sel_w-1:0] peek_sel,
   output logic [word_w-1:0] peek_data
);

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      phase_t phase;
      load_kind_t kind;
      logic ready;
      logic illegal;
      logic fault;
      logic cr0;
      logic xer;
      mem_req_t req;
      wb_t wb;
      logic [sel_w-1:0] target;
      logic [sel_w-1:0] base;
      logic [word_w-1:0] peek;
   } state_t;

   state_t state_reg;
   state_t state_next;
   logic [word_w-1:0] gpr_reg [reg_count];

   // Instruction fields, bit 0 numbered as the least significant bit
   logic [5:0] f_op;
   logic [9:0] f_xo;
   logic [sel_w-1:0] f_target;
   logic [sel_w-1:0] f_base;
   logic [sel_w-1:0] f_index;
   logic [half_w-1:0] f_offset;
   load_kind_t dec_kind;
   logic [word_w-1:0] base_val;
   logic [word_w-1:0] index_val;
   logic [word_w-1:0] addr_calc;
   logic [word_w-1:0] result;
   logic fault_now;
   // Helpers for the checks below, built apart from the datapath
   logic take;
   logic mem_done;
   logic [word_w-1:0] chk_sum;
   logic [word_w-1:0] chk_index_only;
   logic [word_w-1:0] chk_offset_sum;

   assign f_op = instr_word[op_msb:op_lsb];
   assign f_target = instr_word[target_msb:target_lsb];
   assign f_base = instr_word[base_msb:base_lsb];
   assign f_index = instr_word[index_msb:index_lsb];
   assign f_offset = instr_word[half_w-1:0];
   assign f_xo = instr_word[xo_msb:xo_lsb];

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      dec_kind = load_none;
      if (f_op == op_half_unsigned) begin
         dec_kind = load_unsigned;
      end else if (f_op == op_indexed) begin
         case (f_xo)
            xo_signed_update: dec_kind = load_signed_update;
            xo_signed_indexed: dec_kind = load_signed;
            xo_swapped_indexed: dec_kind = load_swapped;
            default: dec_kind = load_none;
         endcase
      end
   end

   // Register zero as base means a literal zero, not its contents
   assign base_val = (f_base == reg_zero) ? word_zero : gpr_reg[f_base];
   assign index_val = (dec_kind == load_unsigned) ?
      {{half_w{f_offset[half_w-1]}}, f_offset} : gpr_reg[f_index];
   assign addr_calc = base_val + index_val;

   always_comb begin
      case (state_reg.kind)
         load_signed_update, load_signed:
            result = {{half_w{mem_rdata[half_w-1]}}, mem_rdata};
         load_swapped:
            result = {half_zero, mem_rdata[byte_w-1:0], mem_rdata[half_w-1:byte_w]};
         default:
            result = {half_zero, mem_rdata};
      endcase
   end

   assign fault_now = mem_align_fault | mem_storage_fault;
   assign take = state_reg.phase == st_idle && state_reg.ready && instr_valid;
   assign mem_done = state_reg.phase == st_wait && mem_ack && !fault_now;
   assign chk_sum = gpr_reg[f_base] + gpr_reg[f_index];
   assign chk_index_only = gpr_reg[f_index];
   assign chk_offset_sum = ((f_base == reg_zero) ? word_zero : gpr_reg[f_base]) +
      word_w'($signed(f_offset));

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_next = state_reg;
      state_next.wb.target_we = 1'b0;
      state_next.wb.base_we = 1'b0;
      state_next.illegal = 1'b0;
      state_next.fault = 1'b0;
      state_next.cr0 = 1'b0;
      state_next.xer = 1'b0;
      state_next.peek = gpr_reg[peek_sel];
      case (state_reg.phase)
         st_idle: begin
            if (instr_valid && state_reg.ready) begin
               if (dec_kind == load_none) begin
                  state_next.illegal = 1'b1;
               end else begin
                  state_next.kind = dec_kind;
                  state_next.target = f_target;
                  state_next.base = f_base;
                  state_next.req.valid = 1'b1;
                  state_next.req.addr = addr_calc;
                  state_next.ready = 1'b0;
                  state_next.phase = st_wait;
               end
            end
         end
         st_wait: begin
            if (mem_ack) begin
               state_next.req.valid = 1'b0;
               state_next.ready = 1'b1;
               state_next.phase = st_idle;
               if (fault_now) begin
                  state_next.fault = 1'b1;
               end else begin
                  state_next.wb.target_we = 1'b1;
                  state_next.wb.target_sel = state_reg.target;
                  state_next.wb.target_data = result;
                  // Only the signed forms may touch condition field 0
                  state_next.cr0 = (state_reg.kind == load_signed) ||
                     (state_reg.kind == load_signed_update);
                  if (state_reg.kind == load_signed_update &&
                      state_reg.base != reg_zero &&
                      state_reg.base != state_reg.target) begin
                     state_next.wb.base_we = 1'b1;
                     state_next.wb.base_sel = state_reg.base;
                     state_next.wb.base_data = state_reg.req.addr;
                  end
               end
            end
         end
         default: state_next.phase = st_idle;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_reg <= '0;
         state_reg.phase <= st_idle;
         state_reg.kind <= load_none;
         state_reg.ready <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   // Register file; write-back lands one cycle after the wb pulse is seen
   generate
      for (genvar i = 0; i < reg_count; i++) begin : g_gpr
         always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               gpr_reg[i] <= word_zero;
            end else if (state_reg.wb.target_we && state_reg.wb.target_sel == sel_w'(i)) begin
               gpr_reg[i] <= state_reg.wb.target_data;
            end else if (state_reg.wb.base_we && state_reg.wb.base_sel == sel_w'(i)) begin
               gpr_reg[i] <= state_reg.wb.base_data;
            end
         end
      end
   endgenerate

   assign instr_ready = state_reg.ready;
   assign instr_illegal = state_reg.illegal;
   assign mem_req = state_reg.req;
   assign wb = state_reg.wb;
   assign load_fault = state_reg.fault;
   assign cr0_update = state_reg.cr0;
   assign xer_update = state_reg.xer;
   assign peek_data = state_reg.peek;

   ////////////////////////////////////////////////////////////////////////////
   a_fault_blocks_wb: assert property (
      @(posedge sys_clk) disable iff (rst)
      state_reg.phase == st_wait && mem_ack && fault_now
      |=> !wb.target_we && !wb.base_we && load_fault)
      else $error("fault did not cancel write-back");
   a_update_base_rule: assert property (
      @(posedge sys_clk) disable iff (rst)
      wb.base_we |-> wb.base_sel != reg_zero && wb.base_sel != wb.target_sel
      && wb.target_we)
      else $error("base update with illegal base");
   a_update_addr_value: assert property (
      @(posedge sys_clk) disable iff (rst)
      wb.base_we |-> wb.base_data == $past(mem_req.addr))
      else $error("base update value not the address");
   a_xer_untouched: assert property (
      @(posedge sys_clk) disable iff (rst)
      !xer_update)
      else $error("exception register touched");
   a_cr0_signed_only: assert property (
      @(posedge sys_clk) disable iff (rst)
      cr0_update |-> $past(state_reg.kind) inside {load_signed, load_signed_update})
      else $error("condition field updated by unsigned load");
   a_req_holds: assert property (
      @(posedge sys_clk) disable iff (rst)
      mem_req.valid && !mem_ack |=> mem_req.valid && $stable(mem_req.addr))
      else $error("request dropped before acknowledge");
   a_gpr_lands: assert property (
      @(posedge sys_clk) disable iff (rst)
      wb.target_we && !wb.base_we |=> gpr_reg[$past(wb.target_sel)] == $past(wb.target_data))
      else $error("register file missed write");
   a_signed_ext: assert property (
      @(posedge sys_clk) disable iff (rst)
      mem_done && state_reg.kind inside {load_signed, load_signed_update}
      |=> wb.target_data[31:16] == {16{wb.target_data[15]}})
      else $error("sign copy wrong");
   a_swap_upper_zero: assert property (
      @(posedge sys_clk) disable iff (rst)
      mem_done && state_reg.kind != load_signed
      && state_reg.kind != load_signed_update |=> wb.target_data[31:16] == half_zero)
      else $error("upper half not cleared");
   a_decode_update: assert property (
      @(posedge sys_clk) disable iff (rst)
      take && f_op == op_indexed && f_xo == xo_signed_update
      |=> state_reg.kind == load_signed_update && mem_req.valid)
      else $error("update indexed load not decoded");
   a_decode_signed: assert property (
      @(posedge sys_clk) disable iff (rst)
      take && f_op == op_indexed && f_xo == xo_signed_indexed
      |=> state_reg.kind == load_signed && mem_req.valid)
      else $error("signed indexed load not decoded");
   a_decode_swapped: assert property (
      @(posedge sys_clk) disable iff (rst)
      take && f_op == op_indexed && f_xo == xo_swapped_indexed
      |=> state_reg.kind == load_swapped && mem_req.valid)
      else $error("swapped load not decoded");
   a_decode_unsigned: assert property (
      @(posedge sys_clk) disable iff (rst)
      take && f_op == op_half_unsigned
      |=> state_reg.kind == load_unsigned && mem_req.valid)
      else $error("unsigned load not decoded");
   a_illegal_pulse: assert property (
      @(posedge sys_clk) disable iff (rst)
      take && dec_kind == load_none |=> instr_illegal && !mem_req.valid && instr_ready)
      else $error("unknown instruction not flagged");
   a_fields_latched: assert property (
      @(posedge sys_clk) disable iff (rst)
      take && dec_kind != load_none
      |=> state_reg.target == $past(f_target) && state_reg.base == $past(f_base))
      else $error("register fields not captured");
   a_index_addr_sum: assert property (
      @(posedge sys_clk) disable iff (rst)
      take && f_op == op_indexed && dec_kind != load_none && f_base != reg_zero
      |=> mem_req.addr == $past(chk_sum))
      else $error("indexed address not the sum");
   a_index_addr_zero: assert property (
      @(posedge sys_clk) disable iff (rst)
      take && f_op == op_indexed && dec_kind != load_none && f_base == reg_zero
      |=> mem_req.addr == $past(chk_index_only))
      else $error("indexed address with zero base wrong");
   a_offset_addr: assert property (
      @(posedge sys_clk) disable iff (rst)
      take && f_op == op_half_unsigned |=> mem_req.addr == $past(chk_offset_sum))
      else $error("offset address wrong");
   a_signed_low: assert property (
      @(posedge sys_clk) disable iff (rst)
      mem_done && state_reg.kind inside {load_signed, load_signed_update}
      |=> wb.target_data[15:0] == $past(mem_rdata))
      else $error("signed halfword not placed");
   a_unsigned_value: assert property (
      @(posedge sys_clk) disable iff (rst)
      mem_done && state_reg.kind == load_unsigned
      |=> wb.target_data == {half_zero, $past(mem_rdata)})
      else $error("unsigned result wrong");
   a_swap_bytes: assert property (
      @(posedge sys_clk) disable iff (rst)
      mem_done && state_reg.kind == load_swapped
      |=> wb.target_data[7:0] == $past(mem_rdata[15:8])
      && wb.target_data[15:8] == $past(mem_rdata[7:0]))
      else $error("bytes not swapped");
   a_update_writes_base: assert property (
      @(posedge sys_clk) disable iff (rst)
      mem_done && state_reg.kind == load_signed_update && state_reg.base != reg_zero
      && state_reg.base != state_reg.target |=> wb.base_we)
      else $error("base update missing");
   a_no_base_other: assert property (
      @(posedge sys_clk) disable iff (rst)
      mem_done && state_reg.kind != load_signed_update |=> !wb.base_we)
      else $error("base written by non-update load");
   a_gpr_base_lands: assert property (
      @(posedge sys_clk) disable iff (rst)
      wb.base_we |=> gpr_reg[$past(wb.base_sel)] == $past(wb.base_data))
      else $error("base register missed write");
   a_cr0_quiet: assert property (
      @(posedge sys_clk) disable iff (rst)
      mem_done && state_reg.kind inside {load_unsigned, load_swapped} |=> !cr0_update)
      else $error("condition field touched");
   a_one_request: assert property (
      @(posedge sys_clk) disable iff (rst)
      mem_req.valid && mem_ack |=> !mem_req.valid && instr_ready)
      else $error("request not closed on acknowledge");
   a_busy_not_ready: assert property (
      @(posedge sys_clk) disable iff (rst)
      state_reg.phase == st_wait |-> !instr_ready && mem_req.valid)
      else $error("ready while load in flight");
endmodule

// >>> test/mem_model.sv
`timescale 1ns/100ps
module mem_model
   import hw_load_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire mem_req_t mem_req,
   input wire logic [1:0] lat,
   input wire logic [1:0] fault_sel,
   output logic mem_ack,
   output logic [half_w-1:0] mem_rdata,
   output logic mem_align_fault,
   output logic mem_storage_fault
);
   logic [1:0] wait_reg;
   // Between answers the data and fault lines toggle, so a late sample shows up as bad data
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         {mem_ack, wait_reg, mem_rdata} <= 19'h00000;
         {mem_align_fault, mem_storage_fault} <= 2'h0;
      end else if (mem_req.valid && !mem_ack && wait_reg == lat) begin
         mem_ack <= 1'b1;
         mem_rdata <= ~(mem_req.addr[15:0] ^ mem_req.addr[31:16]);
         mem_align_fault <= fault_sel == 2'h1;
         mem_storage_fault <= fault_sel == 2'h2;
      end else begin
         mem_ack <= 1'b0;
         wait_reg <= (mem_req.valid && !mem_ack) ? wait_reg + 2'h1 : 2'h0;
         mem_rdata <= ~mem_rdata;
         {mem_align_fault, mem_storage_fault} <= ~{mem_align_fault, mem_storage_fault};
      end
   end
endmodule

// >>> test/tb_halfword_load_execute.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin \
   n_tests++; \
   if ((got) !== (exp)) begin \
      mismatches++; \
      $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); \
   end \
end
module tb_halfword_load_execute
   import hw_load_pkg::*;
;
   logic sys_clk, rst, instr_valid, instr_ready, instr_illegal, mem_ack;
   logic mem_align_fault, mem_storage_fault, load_fault, cr0_update, xer_update;
   logic [word_w-1:0] instr_word, peek_data, r, d;
   logic [half_w-1:0] mem_rdata;
   logic [sel_w-1:0] peek_sel;
   logic [1:0] lat, fault_sel;
   mem_req_t mem_req;
   wb_t wb;
   logic [word_w-1:0] general_register_file [reg_count];
   logic [79:0] notes [$];
   logic [79:0] obs, exp_note;
   logic [31:0] seed = 32'h00005C93;
   int mismatches = 0;
   int n_tests = 0;
   int k;

   halfword_load_execute u_dut (.sys_clk(sys_clk), .rst(rst), .instr_valid(instr_valid),
      .instr_word(instr_word), .instr_ready(instr_ready), .instr_illegal(instr_illegal),
      .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .mem_align_fault(mem_align_fault), .mem_storage_fault(mem_storage_fault), .wb(wb),
      .load_fault(load_fault), .cr0_update(cr0_update), .xer_update(xer_update),
      .peek_sel(peek_sel), .peek_data(peek_data));
   mem_model u_mem (.sys_clk(sys_clk), .rst(rst), .mem_req(mem_req), .lat(lat),
      .fault_sel(fault_sel), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .mem_align_fault(mem_align_fault), .mem_storage_fault(mem_storage_fault));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h00000000);
      return seed;
   endfunction

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Kinds: 0 update, 1 signed, 2 swapped, 3 unsigned, 4 and 5 illegal
   task automatic run(input int k, input logic [4:0] rt, ra, input logic [15:0] low,
                      input logic [1:0] f, input logic [1:0] l);
      logic [31:0] ea, res;
      logic [15:0] h;
      logic bw;
      int i;
      ea = (ra != reg_zero) ? general_register_file[ra] : word_zero;
      ea += (k == 3) ? {{16{low[15]}}, low} : general_register_file[low[15:11]];
      h = ~(ea[15:0] ^ ea[31:16]);
      res = (k == 3) ? {half_zero, h} : (k == 2) ? {half_zero, h[7:0], h[15:8]} : {{16{h[15]}}, h};
      bw = k == 0 && ra != reg_zero && ra != rt && f == 2'h0;
      if (k >= 4) notes.push_back({4'h8, 76'h0});
      else if (f != 2'h0) notes.push_back({4'h4, 76'h0});
      else begin
         notes.push_back({2'h0, 1'(k < 2), 2'h1, rt, res, bw, bw ? {ra, ea} : 37'h0});
         general_register_file[rt] = res;
         if (bw) general_register_file[ra] = ea;
      end
      instr_word = {(k == 3) ? op_half_unsigned : (k == 4) ? 6'h2A : op_indexed, rt, ra, low};
      if (k != 3 && k != 4) instr_word[10:1] = (k == 0) ? xo_signed_update :
         (k == 1) ? xo_signed_indexed : (k == 5) ? 10'h14B : xo_swapped_indexed;
      {fault_sel, lat, instr_valid} = {f, l, 1'b1};
      @(posedge sys_clk);
      #1 instr_valid = 1'b0;
      i = 0;
      do begin
         @(posedge sys_clk);
         #1 i++;
      end while (instr_ready !== 1'b1 && i < 20);
      `CHK(instr_ready, 1'b1)
      repeat (2) @(posedge sys_clk);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   always_comb obs = {instr_illegal, load_fault, cr0_update, xer_update, wb.target_we,
      wb.target_we ? {wb.target_sel, wb.target_data} : 37'h0, wb.base_we,
      wb.base_we ? {wb.base_sel, wb.base_data} : 37'h0};

   always @(posedge sys_clk) begin
      if (!rst && (|obs[79:75] || obs[37])) begin
         exp_note = (notes.size() > 0) ? notes.pop_front() : ~obs;
         `CHK(obs, exp_note)
      end
   end

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   initial begin
      #80000;
      mismatches++;
      conclude();
   end

   initial begin
      {rst, instr_valid, instr_word, peek_sel, lat, fault_sel} = {1'b1, 42'h0};
      repeat (16) @(posedge sys_clk);
      #1 rst = 1'b0;
      foreach (general_register_file[i]) general_register_file[i] = word_zero;
      for (int i = 1; i < 32; i++) begin
         d = rnd();
         run(3, 5'(i), reg_zero, d[15:0], 2'h0, d[17:16]);
      end
      $display("test fill done");
      repeat (300) begin
         r = rnd();
         d = rnd();
         k = (r[2:0] > 3'h5) ? int'(r[1:0]) : int'(r[2:0]);
         run(k, r[7:3], (r[15:14] == 2'h0) ? r[7:3] : (r[9:8] == 2'h0) ? reg_zero : r[14:10],
             d[15:0], (r[18:16] == 3'h0) ? {r[19], ~r[19]} : 2'h0, r[22:21]);
      end
      $display("test random done");
      for (int i = 0; i < 32; i++) begin
         peek_sel = 5'(i);
         @(posedge sys_clk);
         #1 `CHK(peek_data, general_register_file[i])
      end
      `CHK(notes.size(), 0)
      $display("test readback done");
      conclude();
   end
endmodule
